// *** hw/assq_pkg.sv ***
// Constants and types shared by the serial sample sequencer.
package assq_pkg;
    localparam int ASSQ_CMD_BITS = 8;
    localparam int ASSQ_RESULT_BITS = 12;
    localparam logic [3:0] ASSQ_TRACK_AFTER_BIT = 4'h5;
    localparam logic [3:0] ASSQ_HOLD_AFTER_BIT = 4'h8;
    // Conversion steps are counted on rising shift-clock edges after hold.
    localparam logic [3:0] ASSQ_CONV_STEPS = 4'hf;
    localparam logic [3:0] ASSQ_STROBE_STEP = 4'h1;
    localparam logic [3:0] ASSQ_FIRST_DECISION = 4'h2;
    localparam logic [3:0] ASSQ_LAST_DECISION = 4'hd;
    // Command byte field positions, most significant first.
    localparam int ASSQ_START_POS = 7;
    localparam int ASSQ_SEL_HI_POS = 6;
    localparam int ASSQ_SEL_LO_POS = 4;
    localparam int ASSQ_POLARITY_POS = 3;
    localparam int ASSQ_MODE_POS = 2;
    localparam int ASSQ_PWR_HI_POS = 1;
    localparam int ASSQ_PWR_LO_POS = 0;
    // Host-side limits, kept for reference by the bench.
    localparam int ASSQ_DUTY_MIN_PCT = 40;
    localparam int ASSQ_DUTY_MAX_PCT = 60;
    localparam int ASSQ_ACQ_MIN_FAST_NS = 468;
    localparam int ASSQ_ACQ_MIN_SLOW_NS = 625;
    // Reset values.
    localparam logic [11:0] ASSQ_TRIAL_RESET = 12'h800;
    localparam logic [7:0] ASSQ_CMD_RESET = 8'h00;

    typedef enum logic [1:0] {
        ASSQ_WAIT_START = 2'b00,
        ASSQ_COMMAND = 2'b01,
        ASSQ_CONVERT = 2'b10
    } assq_state_type;
endpackage

// *** hw/assq_sequencer.sv ***
// Serial command capture, track/hold sequencing and SAR result shifting.
// Function
// - Sample serial command input on each shift-clock rising edge while select is low and the shutdown input is high, except during conversion.
// - Ignore serial command input completely whenever select is high.
// - Update result output on rising edges; high impedance while select is high.
// - Strobe high one shift-clock period before MSB decision; tri-stated when deselected.
// - Shutdown input low halts conversion activity and powers the converter down.
// - Single-ended: selected channel to positive input, common return to negative.
// - Differential: inputs only from adjacent pairs 0-1, 2-3, 4-5, 6-7.
// - Acquisition spans three shift-clock cycles, ending on falling edge after last bit.
// - Tracking starts on the falling edge after the fifth command bit.
// - Hold starts on the falling edge after the eighth bit, starting conversion.
// - Conversion takes fifteen shift-clock periods, scaling with host clock rate.
// - After conversion, hold capacitor reconnects to positive input and tracks again.
// - Each conversion yields a twelve-bit successive-approximation result.
// - After select falls, leading zeros are discarded; first one is the MSB.
// - Command: start, three channel bits, polarity, input mode, two power bits.
// - Result shifts MSB first; straight binary unipolar, two's complement bipolar.
`timescale 1ns/1ps
module assq_sequencer
    import assq_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic shiftClockPin,
    input wire logic selectNPin,
    input wire logic serialDataInPin,
    input wire logic powerOffRequestN,
    input wire logic comparatorHigh,
    output logic serialDataOut,
    output logic serialDataOutOe,
    output logic conversionStrobeOut,
    output logic conversionStrobeOutOe,
    output logic [2:0] positiveChannel,
    output logic [2:0] negativeChannel,
    output logic negativeIsCommon,
    output logic holdCapacitorTracking,
    output logic converting,
    output logic [11:0] trialCode,
    output logic [1:0] powerModeBits,
    output logic unipolarMode,
    output logic poweredDown
);
    logic [2:0] sclkSync_reg;
    logic [1:0] selNSync_reg;
    logic [1:0] dinSync_reg;
    logic [1:0] pwrSync_reg;
    logic [1:0] cmpSync_reg;
    assq_state_type state_reg;
    logic [3:0] bitCount_reg;
    logic [3:0] step_reg;
    logic [6:0] cmdShift_reg;
    logic [11:0] trial_reg;
    logic dout_reg;
    logic strobe_reg;
    logic outOe_reg;
    logic [2:0] posCh_reg;
    logic [2:0] negCh_reg;
    logic negCom_reg;
    logic track_reg;
    logic [1:0] pwrMode_reg;
    logic unipolar_reg;
    logic down_reg;

    // Only the second stage of each synchroniser is read by logic; the shift clock also has its third stage read for edge detection.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sclkSync_reg <= 3'h0;
            selNSync_reg <= 2'h3;
            dinSync_reg <= 2'h0;
            pwrSync_reg <= 2'h3;
            cmpSync_reg <= 2'h0;
        end else begin
            sclkSync_reg <= {sclkSync_reg[1:0], shiftClockPin};
            selNSync_reg <= {selNSync_reg[0], selectNPin};
            dinSync_reg <= {dinSync_reg[0], serialDataInPin};
            pwrSync_reg <= {pwrSync_reg[0], powerOffRequestN};
            cmpSync_reg <= {cmpSync_reg[0], comparatorHigh};
        end
    end

    wire selected = ~selNSync_reg[1];
    wire shutdown = ~pwrSync_reg[1];
    wire active = selected & ~shutdown;
    wire sclkRise = active & sclkSync_reg[1] & ~sclkSync_reg[2];
    wire sclkFall = active & ~sclkSync_reg[1] & sclkSync_reg[2];
    wire dinBit = dinSync_reg[1];

    wire inWait = (state_reg == ASSQ_WAIT_START);
    wire inCommand = (state_reg == ASSQ_COMMAND);
    wire inConvert = (state_reg == ASSQ_CONVERT);
    wire startSeen = sclkRise & inWait & dinBit;
    wire cmdBitTaken = sclkRise & inCommand & (bitCount_reg < ASSQ_HOLD_AFTER_BIT);
    wire trackEdge = sclkFall & inCommand & (bitCount_reg == ASSQ_TRACK_AFTER_BIT);
    wire holdEdge = sclkFall & inCommand & (bitCount_reg == ASSQ_HOLD_AFTER_BIT);
    wire [3:0] stepNext = step_reg + 4'h1;
    wire convRise = sclkRise & inConvert;
    wire decideNow = convRise & (stepNext >= ASSQ_FIRST_DECISION)
        & (stepNext <= ASSQ_LAST_DECISION);
    wire convDone = convRise & (stepNext == ASSQ_CONV_STEPS);
    wire [3:0] bitIndex = ASSQ_LAST_DECISION - stepNext;

    // The start bit is implied; the shift register holds the seven bits that follow it.
    wire [7:0] cmdByte = {1'b1, cmdShift_reg};
    wire [2:0] chanSel = cmdByte[ASSQ_SEL_HI_POS:ASSQ_SEL_LO_POS];
    wire singleEnded = cmdByte[ASSQ_MODE_POS];
    wire [2:0] pairNeg = {chanSel[2:1], ~chanSel[0]};

    // Bit decided this step: comparator says input is at or above the trial code.
    wire decidedBit = cmpSync_reg[1];
    wire [11:0] bitMask = 12'h001 << bitIndex;
    wire [11:0] resultDecided = decidedBit ? (trial_reg) : (trial_reg & ~bitMask);
    wire [11:0] trialNext = resultDecided | (bitMask >> 1);
    // Bipolar output is two's complement: the offset-binary MSB is inverted.
    wire shiftedBit = (bitIndex == 4'hb) ? (decidedBit ^ ~unipolar_reg) : decidedBit;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= ASSQ_WAIT_START;
            bitCount_reg <= 4'h0;
            step_reg <= 4'h0;
        end else if (!active) begin
            // Deselecting or shutting down abandons the frame and any conversion.
            state_reg <= ASSQ_WAIT_START;
            bitCount_reg <= 4'h0;
            step_reg <= 4'h0;
        end else begin
            unique case (state_reg)
                ASSQ_WAIT_START: begin
                    if (startSeen) begin
                        state_reg <= ASSQ_COMMAND;
                        bitCount_reg <= 4'h1;
                    end
                end
                ASSQ_COMMAND: begin
                    if (cmdBitTaken) begin
                        bitCount_reg <= bitCount_reg + 4'h1;
                    end
                    if (holdEdge) begin
                        state_reg <= ASSQ_CONVERT;
                        step_reg <= 4'h0;
                    end
                end
                ASSQ_CONVERT: begin
                    if (convRise) begin
                        step_reg <= stepNext;
                    end
                    if (convDone) begin
                        state_reg <= ASSQ_WAIT_START;
                        bitCount_reg <= 4'h0;
                    end
                end
                default: begin
                    state_reg <= ASSQ_WAIT_START;
                    bitCount_reg <= 4'h0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmdShift_reg <= ASSQ_CMD_RESET[6:0];
        end else if (startSeen) begin
            cmdShift_reg <= ASSQ_CMD_RESET[6:0];
        end else if (cmdBitTaken) begin
            cmdShift_reg <= {cmdShift_reg[5:0], dinBit};
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            posCh_reg <= 3'h0;
            negCh_reg <= 3'h0;
            negCom_reg <= 1'b1;
            pwrMode_reg <= 2'h0;
            unipolar_reg <= 1'b1;
        end else if (holdEdge) begin
            posCh_reg <= chanSel;
            negCh_reg <= singleEnded ? 3'h0 : pairNeg;
            negCom_reg <= singleEnded;
            pwrMode_reg <= cmdByte[ASSQ_PWR_HI_POS:ASSQ_PWR_LO_POS];
            unipolar_reg <= cmdByte[ASSQ_POLARITY_POS];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            track_reg <= 1'b1;
        end else if (shutdown) begin
            track_reg <= 1'b1;
        end else if (trackEdge || convDone) begin
            track_reg <= 1'b1;
        end else if (holdEdge) begin
            track_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            trial_reg <= ASSQ_TRIAL_RESET;
        end else if (holdEdge) begin
            trial_reg <= ASSQ_TRIAL_RESET;
        end else if (decideNow) begin
            trial_reg <= trialNext;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dout_reg <= 1'b0;
            strobe_reg <= 1'b0;
        end else if (!active) begin
            dout_reg <= 1'b0;
            strobe_reg <= 1'b0;
        end else if (sclkRise) begin
            strobe_reg <= convRise & (stepNext == ASSQ_STROBE_STEP);
            dout_reg <= decideNow ? shiftedBit : 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            outOe_reg <= 1'b0;
            down_reg <= 1'b0;
        end else begin
            outOe_reg <= selected;
            down_reg <= shutdown;
        end
    end

    assign serialDataOut = dout_reg;
    assign serialDataOutOe = outOe_reg;
    assign conversionStrobeOut = strobe_reg;
    assign conversionStrobeOutOe = outOe_reg;
    assign positiveChannel = posCh_reg;
    assign negativeChannel = negCh_reg;
    assign negativeIsCommon = negCom_reg;
    assign holdCapacitorTracking = track_reg;
    // Only the convert code has its upper bit set, so this flag is a plain flop bit.
    assign converting = state_reg[1];
    assign trialCode = trial_reg;
    assign powerModeBits = pwrMode_reg;
    assign unipolarMode = unipolar_reg;
    assign poweredDown = down_reg;
endmodule

// *** sim/assq_sequencer_asserts.sv ***
// Port-level concurrent checks for the serial sample sequencer.
`timescale 1ns/1ps
module assq_sequencer_asserts (
    input wire logic clk,
    input wire logic rst,
    input wire logic shiftClockPin,
    input wire logic selectNPin,
    input wire logic powerOffRequestN,
    input wire logic serialDataOut,
    input wire logic serialDataOutOe,
    input wire logic conversionStrobeOut,
    input wire logic conversionStrobeOutOe,
    input wire logic [2:0] positiveChannel,
    input wire logic [2:0] negativeChannel,
    input wire logic negativeIsCommon,
    input wire logic holdCapacitorTracking,
    input wire logic converting,
    input wire logic [11:0] trialCode,
    input wire logic poweredDown
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [7:0] convCount_reg;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) convCount_reg <= 8'h00;
        else convCount_reg <= converting ? convCount_reg + 8'h01 : 8'h00;
    end
    // Only a conversion that ran with select low and power on may be timed.
    sequence convEnd;
        $fell(converting) && !selectNPin && powerOffRequestN;
    endsequence
    chk_dout_float: assert property (selectNPin [*5] |-> !serialDataOutOe)
        else $error("result pin driven while deselected");
    chk_strobe_float: assert property (selectNPin [*5] |-> !conversionStrobeOutOe)
        else $error("strobe pin driven while deselected");
    chk_dout_on_rise: assert property ($rose(serialDataOut) |-> $past(shiftClockPin, 3))
        else $error("result bit changed away from a shift clock rise");
    chk_strobe_width: assert property ($rose(conversionStrobeOut) |->
        conversionStrobeOut [*6] ##[2:3] !conversionStrobeOut) else $error("strobe width wrong");
    chk_hold_starts: assert property ($fell(holdCapacitorTracking) |->
        converting && trialCode == 12'h800) else $error("hold without conversion start");
    chk_hold_on_fall: assert property ($fell(holdCapacitorTracking) |->
        !shiftClockPin && $past(shiftClockPin, 5) && $past(holdCapacitorTracking, 40))
        else $error("hold not on a falling edge after tracking");
    chk_conv_length: assert property (convEnd |-> convCount_reg inside {[8'h73:8'h75]})
        else $error("conversion length wrong");
    chk_track_resume: assert property (convEnd |-> ##[0:1] holdCapacitorTracking)
        else $error("tracking not resumed after conversion");
    chk_shutdown: assert property (!powerOffRequestN [*5] |-> poweredDown && !converting)
        else $error("shutdown not honoured");
    chk_deselect_idle: assert property (selectNPin [*5] |-> !converting)
        else $error("conversion while deselected");
    chk_pair_route: assert property (converting |-> negativeChannel ==
        (negativeIsCommon ? 3'h0 : positiveChannel ^ 3'h1)) else $error("input pair wrong");
    cover property ($rose(conversionStrobeOut));
    cover property ($fell(converting) && !powerOffRequestN);
    cover property (convEnd);
endmodule
bind assq_sequencer assq_sequencer_asserts i_chk (
    .clk(clk),
    .rst(rst),
    .shiftClockPin(shiftClockPin),
    .selectNPin(selectNPin),
    .powerOffRequestN(powerOffRequestN),
    .serialDataOut(serialDataOut),
    .serialDataOutOe(serialDataOutOe),
    .conversionStrobeOut(conversionStrobeOut),
    .conversionStrobeOutOe(conversionStrobeOutOe),
    .positiveChannel(positiveChannel),
    .negativeChannel(negativeChannel),
    .negativeIsCommon(negativeIsCommon),
    .holdCapacitorTracking(holdCapacitorTracking),
    .converting(converting),
    .trialCode(trialCode),
    .poweredDown(poweredDown)
);

// *** sim/assq_host_model.sv ***
// Serial host model: shift clock, select and command data for the sequencer.
`timescale 1ns/1ps
module assq_host_model (
    input wire logic clk,
    input wire logic doutLine,
    input wire logic strobeLine,
    output logic shiftClockPin,
    output logic selectNPin,
    output logic serialDataInPin
);
    initial begin
        shiftClockPin = 1'b0;
        selectNPin = 1'b1;
        serialDataInPin = 1'b0;
    end
    // Equal halves keep the high time at half the period.
    task automatic tick(input logic b, input int h, output logic o, output logic t);
        serialDataInPin <= b;
        repeat (h - 1) @(posedge clk);
        @(negedge clk);
        o = doutLine;
        t = strobeLine;
        @(posedge clk);
        shiftClockPin <= 1'b1;
        repeat (h) @(posedge clk);
        shiftClockPin <= 1'b0;
    endtask
    task automatic frame(input logic [7:0] cmd, input int lead, output logic [15:0] d,
        output logic [15:0] s);
        logic o;
        logic t;
        @(posedge clk);
        selectNPin <= 1'b0;
        repeat (2) @(posedge clk);
        // Bits six to eight run at half rate so the sample window outlasts acquisition.
        for (int i = 0; i < lead + 24; i++) begin
            tick(i >= lead && i < lead + 8 ? cmd[7 - (i - lead)] : 1'b0,
                (i >= lead + 5 && i < lead + 8) ? 8 : 4, o, t);
            d = {d[14:0], o};
            s = {s[14:0], t};
        end
        selectNPin <= 1'b1;
        repeat (5) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic noise(input logic [15:0] bits);
        logic o;
        logic t;
        @(posedge clk);
        for (int i = 0; i < 16; i++) tick(bits[i], 4, o, t);
        @(negedge clk);
    endtask
endmodule

// *** sim/test_adc_serial_sample_sequencer.sv ***
// Self-checking bench for the serial sample sequencer.
`timescale 1ns/1ps
module test_adc_serial_sample_sequencer;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic powerOffRequestN = 1'b1;
    logic shiftClockPin, selectNPin, serialDataInPin, comparatorHigh, serialDataOut;
    logic serialDataOutOe, conversionStrobeOut, conversionStrobeOutOe, negativeIsCommon;
    logic holdCapacitorTracking, converting, unipolarMode, poweredDown;
    logic [2:0] positiveChannel, negativeChannel;
    logic [1:0] powerModeBits;
    logic [11:0] trialCode;
    logic [11:0] analogLevel = 12'h000;
    logic [15:0] d, s;
    wire doutLine = serialDataOutOe ? serialDataOut : 1'bz;
    wire strobeLine = conversionStrobeOutOe ? conversionStrobeOut : 1'bz;
    int mismatches = 0;
    int checks = 0;
    int unsigned seed = 69533;
    int expq[$];
    // The comparator stands in for the analog side: it keeps a trial bit at or below the input.
    assign comparatorHigh = analogLevel >= trialCode;
    always #10 clk = ~clk;
    assq_sequencer i_dut (
        .clk(clk),
        .rst(rst),
        .shiftClockPin(shiftClockPin),
        .selectNPin(selectNPin),
        .serialDataInPin(serialDataInPin),
        .powerOffRequestN(powerOffRequestN),
        .comparatorHigh(comparatorHigh),
        .serialDataOut(serialDataOut),
        .serialDataOutOe(serialDataOutOe),
        .conversionStrobeOut(conversionStrobeOut),
        .conversionStrobeOutOe(conversionStrobeOutOe),
        .positiveChannel(positiveChannel),
        .negativeChannel(negativeChannel),
        .negativeIsCommon(negativeIsCommon),
        .holdCapacitorTracking(holdCapacitorTracking),
        .converting(converting),
        .trialCode(trialCode),
        .powerModeBits(powerModeBits),
        .unipolarMode(unipolarMode),
        .poweredDown(poweredDown)
    );
    assq_host_model i_host (
        .clk(clk),
        .doutLine(doutLine),
        .strobeLine(strobeLine),
        .shiftClockPin(shiftClockPin),
        .selectNPin(selectNPin),
        .serialDataInPin(serialDataInPin)
    );
    function automatic int unsigned xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] want);
        checks++;
        if (seen !== want) begin
            mismatches++;
            $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, want);
        end
    endtask
    task automatic final_report();
        $display("Counts: %0d checks, %0d mismatches", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        mismatches++;
        final_report();
    end
    initial begin
        int unsigned r;
        int a;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        i_host.noise(16'(xs()) | 16'h8001);
        chk(16'({converting, serialDataOutOe, conversionStrobeOutOe}), 16'h0000);
        $display("Deselected noise done");
        fork
            i_host.frame(8'h8f, 0, d, s);
            begin
                repeat (180) @(posedge clk);
                powerOffRequestN <= 1'b0;
                repeat (6) @(negedge clk);
                chk(16'({poweredDown, converting, holdCapacitorTracking}), 16'h0005);
                @(posedge clk);
                powerOffRequestN <= 1'b1;
            end
        join
        $display("Shutdown abort done");
        for (int i = 0; i < 16; i++) begin
            r = xs();
            a = i == 15 ? 4095 : i == 0 ? 0 : int'((r >> 12) % 4096);
            @(posedge clk);
            analogLevel <= a[11:0];
            expq.push_back(r[0] ? a : a ^ 2048);
            i_host.frame({1'b1, i[2:0], r[0], i[3], r[2:1]}, int'((r >> 8) % 4), d, s);
            chk(d & 16'h7ffe, 16'(expq.pop_front() << 2));
            chk(s, 16'h4000);
            chk(16'({positiveChannel, negativeIsCommon, negativeChannel, unipolarMode,
                powerModeBits}), 16'({i[2:0], i[3], i[3] ? 3'h0 : i[2:0] ^ 3'h1, r[0], r[2:1]}));
            chk(16'({converting, holdCapacitorTracking, serialDataOutOe}), 16'h0002);
        end
        $display("Channel sweep done");
        final_report();
    end
endmodule
